// ==== common/ddmf_pkg.sv ====
package ddmf_pkg;
    // ************************************************************
    // Widths
    // ************************************************************
    localparam int ADDR_ENG_W = 28;
    localparam int DATA_ENG_W = 16;
    localparam int WORD_ADDR_W = 24;
    localparam int BIT_SEL_W = 4;
    localparam int REG_IDX_W = 4;
    // ************************************************************
    // Bus cycle type codes
    // ************************************************************
    localparam logic [1:0] CYC_OPERAND = 2'h0;
    localparam logic [1:0] CYC_FETCH = 2'h1;
    localparam logic [1:0] CYC_DRAW_ADDR = 2'h2;
    localparam logic [1:0] CYC_IDLE_ADDR = 2'h3;
    // ************************************************************
    // Opcodes (instruction bits 15:12)
    // ************************************************************
    localparam logic [3:0] OP_A_ADD = 4'h0;
    localparam logic [3:0] OP_A_SUB = 4'h1;
    localparam logic [3:0] OP_A_MOV = 4'h2;
    localparam logic [3:0] OP_D_ADD = 4'h3;
    localparam logic [3:0] OP_D_SUB = 4'h4;
    localparam logic [3:0] OP_D_AND = 4'h5;
    localparam logic [3:0] OP_D_OR = 4'h6;
    localparam logic [3:0] OP_D_XOR = 4'h7;
    localparam logic [3:0] OP_D_MOV = 4'h8;
    localparam logic [3:0] OP_LD_D = 4'h9;
    localparam logic [3:0] OP_LD_A = 4'hA;
    localparam logic [3:0] OP_ST_D = 4'hB;
    localparam logic [3:0] OP_ST_A = 4'hC;
    localparam logic [3:0] OP_DRAW = 4'hD;
    localparam logic [3:0] OP_HALT = 4'hF;
    // ************************************************************
    // Reset value and fixed draw register numbers
    // ************************************************************
    localparam logic [23:0] PC_RESET = 24'h000000;
    localparam logic [3:0] DRAW_ADDR_REG = 4'hF;
    localparam logic [3:0] DRAW_SEL_REG = 4'hF;
    localparam logic [3:0] DRAW_SCRATCH_REG = 4'hE;
endpackage : ddmf_pkg

// ==== design/ddmf_core.sv ====
// How it works
// RULE1 - Address engine: 28-bit ALU, sixteen 28-bit private registers.
// RULE2 - Data engine: 16-bit ALU, sixteen 16-bit private registers.
// RULE3 - Arithmetic is register to register, only within one engine's bank; draw adds data reg F bits 3:0 to address reg F shifted left four into reg E.
// RULE4 - One sequencer decodes one fetched instruction stream for both engines.
// RULE5 - Simple ops touch only named registers; draw uses fixed scratch registers.
// RULE6 - 24-bit word addresses over a flat space of 16-bit words.
// RULE7 - Bit address is word address shifted left four plus 4-bit select.
// RULE8 - Short elements are kept justified toward bit 0.
// RULE9 - Multiword values: low word at lowest address, referenced by it.
// RULE10 - Loads into narrower registers keep low bits, drop upper bits.
// RULE11 - Stores place value low and zero-fill unused upper bits.
// RULE12 - Shared lines carry low 16 address bits first, then data.
// RULE13 - Two-bit cycle code: 00 operand, 01 fetch, others address only.
`timescale 1ns/100ps
`default_nettype none
module ddmf_core #(
    parameter int ADDR_W = 28,
    parameter int DATA_W = 16
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [15:0] ad_in,
    output logic [15:0] ad_out,
    output logic ad_oe,
    output logic [7:0] addr_high,
    output logic addr_latch,
    output logic write_strobe,
    output logic read_strobe,
    output logic [1:0] bus_cycle_type_code,
    output logic [3:0] bit_select,
    output logic halted
);
    // ************************************************************
    // Sequencer states
    // ************************************************************
    typedef enum logic [2:0] {
        S_FETCH_ADDR, S_FETCH_DATA, S_OPER, S_MEM_ADDR, S_MEM_DATA, S_DRAW, S_HALT
    } ddmf_state_t;

    // Extend or cut to the 28-bit engine width, keeping bit 0 justified
    function automatic logic [ADDR_W-1:0] ddmf_bit_addr(input logic [23:0] wa, input logic [3:0] sel);
        ddmf_bit_addr = ADDR_W'({wa, 4'h0}) + ADDR_W'(sel); // RULE7
    endfunction : ddmf_bit_addr

    ddmf_state_t state_reg, state_next;
    logic [ADDR_W-1:0] a_bank_reg [16]; // RULE1
    logic [ADDR_W-1:0] a_bank_next [16];
    logic [DATA_W-1:0] d_bank_reg [16]; // RULE2
    logic [DATA_W-1:0] d_bank_next [16];
    logic [23:0] pc_reg, pc_next;
    logic [15:0] ir_reg, ir_next;
    logic [23:0] maddr_reg, maddr_next;
    logic half_reg, half_next;
    logic [15:0] ad_out_next;
    logic ad_oe_next, addr_latch_next, write_next, read_next, halted_next;
    logic [7:0] addr_high_next;
    logic [1:0] bus_code_next;
    logic [3:0] bit_select_next;
    logic [3:0] op, rd, rs;
    logic [ADDR_W-1:0] a_sum;
    logic [DATA_W-1:0] d_res;
    logic [ADDR_W-1:0] draw_addr;

    assign op = ir_reg[15:12];
    assign rd = ir_reg[7:4];
    assign rs = ir_reg[3:0];

    // ************************************************************
    // Sequencer and both engines
    // ************************************************************
    // Engines compute every cycle; the sequencer picks which result lands
    always_comb begin
        state_next = state_reg;
        a_bank_next = a_bank_reg;
        d_bank_next = d_bank_reg;
        pc_next = pc_reg;
        ir_next = ir_reg;
        maddr_next = maddr_reg;
        half_next = half_reg;
        ad_out_next = 16'h0000;
        ad_oe_next = 1'b0;
        addr_high_next = 8'h00;
        addr_latch_next = 1'b0;
        write_next = 1'b0;
        read_next = 1'b0;
        bus_code_next = ddmf_pkg::CYC_IDLE_ADDR;
        bit_select_next = 4'h0;
        halted_next = 1'b0;
        a_sum = (op == ddmf_pkg::OP_A_SUB) ? a_bank_reg[rd] - a_bank_reg[rs] : a_bank_reg[rd] + a_bank_reg[rs];
        // Bit address held in a variable, since a function result cannot be part-selected
        draw_addr = ddmf_bit_addr(a_bank_reg[ddmf_pkg::DRAW_ADDR_REG][23:0],
                                  d_bank_reg[ddmf_pkg::DRAW_SEL_REG][3:0]); // RULE7
        unique case (op)
            ddmf_pkg::OP_D_ADD: d_res = d_bank_reg[rd] + d_bank_reg[rs];
            ddmf_pkg::OP_D_SUB: d_res = d_bank_reg[rd] - d_bank_reg[rs];
            ddmf_pkg::OP_D_AND: d_res = d_bank_reg[rd] & d_bank_reg[rs];
            ddmf_pkg::OP_D_OR: d_res = d_bank_reg[rd] | d_bank_reg[rs];
            ddmf_pkg::OP_D_XOR: d_res = d_bank_reg[rd] ^ d_bank_reg[rs];
            default: d_res = d_bank_reg[rs];
        endcase
        unique case (state_reg)
            S_FETCH_ADDR: begin
                ad_out_next = pc_reg[15:0]; // RULE12
                ad_oe_next = 1'b1;
                addr_high_next = pc_reg[23:16]; // RULE6
                addr_latch_next = 1'b1;
                bus_code_next = ddmf_pkg::CYC_FETCH; // RULE13
                state_next = S_FETCH_DATA;
            end
            S_FETCH_DATA: begin
                read_next = 1'b1;
                bus_code_next = ddmf_pkg::CYC_FETCH;
                ir_next = ad_in; // RULE4
                pc_next = pc_reg + 24'h000001;
                state_next = S_OPER;
            end
            S_OPER: begin
                half_next = 1'b0;
                // Memory ops take their word address from an address register
                maddr_next = a_bank_reg[rs][23:0]; // RULE6
                unique case (op)
                    ddmf_pkg::OP_A_ADD, ddmf_pkg::OP_A_SUB, ddmf_pkg::OP_A_MOV: begin
                        a_bank_next[rd] = (op == ddmf_pkg::OP_A_MOV) ? a_bank_reg[rs] : a_sum; // RULE3 RULE5
                        state_next = S_FETCH_ADDR;
                    end
                    ddmf_pkg::OP_D_ADD, ddmf_pkg::OP_D_SUB, ddmf_pkg::OP_D_AND, ddmf_pkg::OP_D_OR,
                    ddmf_pkg::OP_D_XOR, ddmf_pkg::OP_D_MOV: begin
                        d_bank_next[rd] = d_res; // RULE3 RULE5
                        state_next = S_FETCH_ADDR;
                    end
                    ddmf_pkg::OP_LD_D, ddmf_pkg::OP_LD_A, ddmf_pkg::OP_ST_D, ddmf_pkg::OP_ST_A:
                        state_next = S_MEM_ADDR;
                    ddmf_pkg::OP_DRAW: state_next = S_DRAW;
                    ddmf_pkg::OP_HALT: state_next = S_HALT;
                    default: state_next = S_FETCH_ADDR; // Unused codes act as no-ops
                endcase
            end
            S_MEM_ADDR: begin
                ad_out_next = maddr_reg[15:0]; // RULE12
                ad_oe_next = 1'b1;
                addr_high_next = maddr_reg[23:16];
                addr_latch_next = 1'b1;
                bus_code_next = ddmf_pkg::CYC_OPERAND; // RULE13
                state_next = S_MEM_DATA;
            end
            S_MEM_DATA: begin
                bus_code_next = ddmf_pkg::CYC_OPERAND;
                // Address engine values span two words, low word first
                state_next = S_FETCH_ADDR;
                unique case (op)
                    ddmf_pkg::OP_LD_D: begin
                        read_next = 1'b1;
                        d_bank_next[rd] = ad_in; // RULE8
                    end
                    ddmf_pkg::OP_LD_A: begin
                        read_next = 1'b1;
                        if (!half_reg) begin
                            a_bank_next[rd][15:0] = ad_in; // RULE9
                        end else begin
                            a_bank_next[rd][ADDR_W-1:16] = ad_in[ADDR_W-17:0]; // RULE10
                        end
                    end
                    ddmf_pkg::OP_ST_D: begin
                        write_next = 1'b1;
                        ad_oe_next = 1'b1;
                        ad_out_next = d_bank_reg[rd];
                    end
                    default: begin
                        write_next = 1'b1;
                        ad_oe_next = 1'b1;
                        ad_out_next = half_reg ? {4'h0, a_bank_reg[rd][ADDR_W-1:16]} // RULE11
                                               : a_bank_reg[rd][15:0]; // RULE9
                    end
                endcase
                if ((op == ddmf_pkg::OP_LD_A || op == ddmf_pkg::OP_ST_A) && !half_reg) begin
                    half_next = 1'b1;
                    maddr_next = maddr_reg + 24'h000001; // RULE9
                    state_next = S_MEM_ADDR;
                end
            end
            S_DRAW: begin
                // Draw issues one address-only cycle at the bit address in fixed registers
                ad_out_next = draw_addr[19:4];
                ad_oe_next = 1'b1;
                addr_high_next = a_bank_reg[ddmf_pkg::DRAW_ADDR_REG][23:16];
                addr_latch_next = 1'b1;
                bit_select_next = d_bank_reg[ddmf_pkg::DRAW_SEL_REG][3:0]; // RULE7
                bus_code_next = ddmf_pkg::CYC_DRAW_ADDR; // RULE13
                // Scratch register keeps the full bit address, a side effect software must expect
                a_bank_next[ddmf_pkg::DRAW_SCRATCH_REG] = draw_addr; // RULE5
                state_next = S_FETCH_ADDR;
            end
            S_HALT: begin
                halted_next = 1'b1; // Only reset leaves halt in this core
            end
            default: state_next = S_FETCH_ADDR;
        endcase
    end

    // Register everything; outputs come straight from flops
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_reg <= S_FETCH_ADDR;
            for (int i = 0; i < 16; i++) begin
                a_bank_reg[i] <= '0;
                d_bank_reg[i] <= '0;
            end
            pc_reg <= ddmf_pkg::PC_RESET;
            ir_reg <= 16'h0000;
            maddr_reg <= 24'h000000;
            half_reg <= 1'b0;
            ad_out <= 16'h0000;
            ad_oe <= 1'b0;
            addr_high <= 8'h00;
            addr_latch <= 1'b0;
            write_strobe <= 1'b0;
            read_strobe <= 1'b0;
            bus_cycle_type_code <= ddmf_pkg::CYC_IDLE_ADDR;
            bit_select <= 4'h0;
            halted <= 1'b0;
        end else begin
            state_reg <= state_next;
            a_bank_reg <= a_bank_next;
            d_bank_reg <= d_bank_next;
            pc_reg <= pc_next;
            ir_reg <= ir_next;
            maddr_reg <= maddr_next;
            half_reg <= half_next;
            ad_out <= ad_out_next;
            ad_oe <= ad_oe_next;
            addr_high <= addr_high_next;
            addr_latch <= addr_latch_next;
            write_strobe <= write_next;
            read_strobe <= read_next;
            bus_cycle_type_code <= bus_code_next;
            bit_select <= bit_select_next;
            halted <= halted_next;
        end
    end
endmodule : ddmf_core
`default_nettype wire

// ==== verif/ddmf_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
module ddmf_chk (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [15:0] ad_out,
    input wire logic ad_oe,
    input wire logic [7:0] addr_high,
    input wire logic addr_latch,
    input wire logic write_strobe,
    input wire logic read_strobe,
    input wire logic [1:0] bus_cycle_type_code,
    input wire logic [3:0] bit_select,
    input wire logic halted
);
    // ************************************************************
    // Bus cycle checks
    // ************************************************************
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    a_fetch_first: assert property ($fell(sys_rst) |-> ##[1:2]
        (addr_latch && bus_cycle_type_code == 2'h1 && ad_out == 16'h0000)) else $error("no fetch at zero");
    a_latch_data: assert property (addr_latch && bus_cycle_type_code inside {2'h0, 2'h1}
        |=> read_strobe != write_strobe) else $error("no data phase");
    a_strobe_latch: assert property (read_strobe || write_strobe |-> $past(addr_latch))
        else $error("data phase without address");
    a_fetch_read: assert property (addr_latch && bus_cycle_type_code == 2'h1
        |=> read_strobe && bus_cycle_type_code == 2'h1) else $error("fetch not read");
    a_write_drive: assert property (write_strobe |-> ad_oe && !read_strobe) else $error("write undriven");
    a_read_release: assert property (read_strobe |-> !ad_oe) else $error("read while driving");
    a_store_code: assert property (write_strobe |-> bus_cycle_type_code == 2'h0) else $error("bad write code");
    a_high_zero: assert property (!addr_latch |-> addr_high == 8'h00) else $error("stray high address");
    a_halt_stays: assert property (halted |=> halted && !addr_latch) else $error("left halt");
    a_bit_draw: assert property (bit_select != 4'h0 |-> bus_cycle_type_code == 2'h2) else $error("stray select");
endmodule : ddmf_chk
bind ddmf_core ddmf_chk ddmf_chk_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .ad_out(ad_out), .ad_oe(ad_oe),
    .addr_high(addr_high), .addr_latch(addr_latch), .write_strobe(write_strobe), .read_strobe(read_strobe),
    .bus_cycle_type_code(bus_cycle_type_code), .bit_select(bit_select), .halted(halted));
`default_nettype wire

// ==== verif/ddmf_mem.sv ====
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// Flat word memory on the shared lines
// ************************************************************
module ddmf_mem (
    input wire logic ref_clk,
    input wire logic [15:0] ad_out,
    input wire logic [7:0] addr_high,
    input wire logic addr_latch,
    input wire logic write_strobe,
    output logic [15:0] ad_in
);
    logic [15:0] mem [logic [23:0]];
    logic [23:0] addr_reg = 24'h000000;
    logic hold_reg = 1'b0;
    logic flip_reg = 1'b0;
    // Unwritten words read as zero
    function automatic logic [15:0] rd(input logic [23:0] a);
        return mem.exists(a) ? mem[a] : 16'h0000;
    endfunction : rd
    // Latch the word address, commit writes in the data phase
    always @(posedge ref_clk) begin
        flip_reg <= ~flip_reg;
        hold_reg <= addr_latch;
        if (addr_latch) begin
            addr_reg <= {addr_high, ad_out};
        end
        if (write_strobe) begin
            mem[addr_reg] = ad_out;
        end
    end
    // Data stands one cycle past the address; a toggling pattern otherwise, so stale data never passes
    assign ad_in = addr_latch ? rd({addr_high, ad_out}) : hold_reg ? rd(addr_reg) : {8{flip_reg, ~flip_reg}};
endmodule : ddmf_mem
`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] ad_in, ad_out;
    logic [7:0] addr_high;
    logic [3:0] bit_select;
    logic [1:0] code;
    logic ad_oe, addr_latch, write_strobe, read_strobe, halted;
    int n_fail = 0;
    int num_checks = 0;
    int cyc = 0;
    // Loads, moves, sums, stores, one draw, an unused opcode, then halt
    logic [15:0] prog [15] = '{16'hA010, 16'h4000, 16'hA021, 16'h90F1, 16'h2032, 16'h0032, 16'hC032, 16'h9011,
        16'h3011, 16'h20F2, 16'hD000, 16'hC0E3, 16'hB011, 16'hE000, 16'hF000};
    // ************************************************************
    // Clock, design and far side
    // ************************************************************
    always #50 ref_clk = ~ref_clk;
    ddmf_core ddmf_core_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe),
        .addr_high(addr_high), .addr_latch(addr_latch), .write_strobe(write_strobe), .read_strobe(read_strobe),
        .bus_cycle_type_code(code), .bit_select(bit_select), .halted(halted));
    ddmf_mem ddmf_mem_inst (.ref_clk(ref_clk), .ad_out(ad_out), .addr_high(addr_high), .addr_latch(addr_latch),
        .write_strobe(write_strobe), .ad_in(ad_in));
    // Hang guard, far above the few hundred cycles that all eight runs take together
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test
    task automatic check16(input string name, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : check16
    // Reset, run the program on two data words, check what it left in memory
    task automatic run_case(input logic [15:0] r0, input logic [15:0] r1);
        logic [27:0] a2;
        logic [27:0] a3;
        logic [27:0] a14;
        int k;
        int n_draw;
        a2 = {r1[11:0], r0};
        a3 = a2 + a2;
        a14 = {a2[23:0], 4'h0} + {24'h000000, r0[3:0]};
        ddmf_mem_inst.mem.delete();
        foreach (prog[i]) ddmf_mem_inst.mem[24'(i)] = prog[i];
        ddmf_mem_inst.mem[24'h00A010] = r0;
        ddmf_mem_inst.mem[24'h00A011] = r1;
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        k = 0;
        n_draw = 0;
        // Look at the bus on the falling edge, where every output has settled
        while (halted !== 1'b1 && k < 2000) begin
            @(negedge ref_clk);
            k++;
            if (code == 2'h2) begin
                n_draw++;
                check16("draw_word", a2[15:0], ad_out);
                check16("draw_high", {8'h00, a2[23:16]}, {8'h00, addr_high});
                check16("draw_select", {12'h000, r0[3:0]}, {12'h000, bit_select});
            end
        end
        repeat (2) @(posedge ref_clk);
        check16("draw_count", 16'h0001, 16'(n_draw));
        check16("halted", 16'h0001, {15'h0000, halted});
        check16("sum_low", a3[15:0], ddmf_mem_inst.rd(a2[23:0]));
        check16("sum_high", {4'h0, a3[27:16]}, ddmf_mem_inst.rd(a2[23:0] + 24'h000001));
        check16("bit_low", a14[15:0], ddmf_mem_inst.rd(a3[23:0]));
        check16("bit_high", {4'h0, a14[27:16]}, ddmf_mem_inst.rd(a3[23:0] + 24'h000001));
        check16("data_sum", r0 + r0, ddmf_mem_inst.rd(24'h00A010));
        check16("untouched", r1, ddmf_mem_inst.rd(24'h00A011));
    endtask : run_case
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        int seed;
        seed = $urandom(43);
        run_case(16'hFFFF, 16'hFF3F);
        run_case(16'h0000, 16'h0030);
        for (int i = 0; i < 6; i++) begin
            run_case(16'($urandom()), {8'($urandom()), 4'h3, 4'($urandom())});
        end
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
